// file: rcd_core.sv
// Function
// - Decode and execute each word in one cycle
// - Fixed 16-bit words, any register with accumulator
// - Bit 15 selects immediate or register source
// - Low byte source: module nibble, index nibble
// - Bits 8-14 name destination module and subindex
// - Upper destinations need prefix, one extra cycle
// - Writes to modules 9, 12, 13, 15 flag side-effect operations
// - Sixteen-entry 16-bit hardware stack
// - Stack used by calls, returns, irq, push/pop
// - Stack index resets to 0Fh
// - Push-type: increment index, then write
// - Pop-type: read entry, then decrement index
// - Three data pointers auto increment or decrement
// - Harvard default, selectable cross-mapping modes
// - Utility ROM 4kB at 8000h
// - Reset starts in ROM, then user or routine
// - Password is program words 0010h-001Fh
// - Lock set blocks debug until password matches
// - Lock clear opens debug without password
// - Mass erase leaves password all ones
// - Host sets loader entry during reset via JTAG
// - Loader defaults to JTAG; UART via application
`timescale 1ns/1ps
module rcd_core
   import rcd_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Instruction stream
   input wire logic [15:0] insn_i,
   input wire logic [15:0] src_data_i,
   input wire logic [15:0] acc_i,
   input wire logic [15:0] pc_i,
   input wire rcd_stk_e stk_op_i,
   input wire logic [15:0] stk_wdata_i,
   input wire logic [1:0] dp_sel_i,
   input wire logic dp_access_i,
   input wire logic [NUM_DP-1:0] dp_inc_i,
   input wire logic [NUM_DP-1:0] dp_dec_i,
   input wire logic [15:0] dp_load_i,
   input wire logic dp_load_en_i,
   input wire rcd_map_e map_mode_i,
   // Lock and loader control
   input wire logic code_lock_clr_i,
   input wire logic mass_erase_i,
   input wire logic [15:0] pwd_word_i,
   input wire logic pwd_word_en_i,
   input wire logic [15:0] flash_word_i,
   input wire logic flash_word_en_i,
   input wire logic [3:0] flash_word_idx_i,
   input wire logic jtag_loader_set_i,
   input wire logic app_loader_cfg_i,
   input wire logic app_port_uart_i,
   // Decode outputs
   output logic [15:0] src_val_o,
   output logic [3:0] dst_mod_o,
   output logic [4:0] dst_sub_o,
   output logic dst_we_o,
   output logic side_fx_o,
   output logic [15:0] stk_rdata_o,
   output logic [3:0] stack_index_o,
   output logic [15:0] dp_o [NUM_DP],
   output logic [15:0] boot_pc_o,
   output logic rom_sel_o,
   output logic code_lock_bit_o,
   output logic debug_ok_o,
   output logic loader_entry_bit_o,
   output logic loader_port_select_o,
   output logic map_data_in_code_o,
   output logic map_code_in_data_o
);

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   rcd_dec_s dec;
   logic [2:0] dest_prefix_reg;
   logic pfx_valid;
   logic [2:0] next_dest_prefix_reg;
   logic next_pfx_valid;
   logic [15:0] next_src_val;

   always_comb begin
      dec.imm = ~insn_i[FMT_BIT];
      dec.src = insn_i[7:0];
      dec.src_mod = insn_i[SRC_MOD_LSB +: 4];
      dec.src_idx = insn_i[SRC_IDX_LSB +: 4];
      dec.dst_mod = insn_i[DST_MOD_LSB +: 4];
      dec.dst_sub = {pfx_valid ? dest_prefix_reg[1:0] : 2'b00, insn_i[DST_SUB_LSB +: 3]};
      dec.pfx_used = pfx_valid;
   end

   // A prefix write only arms the next word; that is the extra cycle.
   always_comb begin
      next_dest_prefix_reg = dest_prefix_reg;
      next_pfx_valid = 1'b0;
      if (dec.dst_mod == MOD_PFX && dec.dst_sub[2:0] == 3'd0) begin
         next_dest_prefix_reg = next_src_val[2:0];
         next_pfx_valid = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dest_prefix_reg <= 3'h0;
         pfx_valid <= 1'b0;
      end else begin
         dest_prefix_reg <= next_dest_prefix_reg;
         pfx_valid <= next_pfx_valid;
      end
   end

   // ----------------------------------------------------------------
   // Decode result registers
   // ----------------------------------------------------------------
   logic next_side_fx;

   always_comb begin
      next_src_val = dec.imm ? {8'h00, dec.src} : src_data_i;
      if (dec.src_mod == MOD_ACC && !dec.imm) begin
         next_src_val = acc_i;
      end
      next_side_fx = (dec.dst_mod == MOD_ACC) || (dec.dst_mod == MOD_IP) ||
                     (dec.dst_mod == MOD_STK) || (dec.dst_mod == MOD_DP);
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         src_val_o <= 16'h0000;
         dst_mod_o <= 4'h0;
         dst_sub_o <= 5'h00;
         dst_we_o <= 1'b0;
         side_fx_o <= 1'b0;
      end else begin
         src_val_o <= next_src_val;
         dst_mod_o <= dec.dst_mod;
         dst_sub_o <= dec.dst_sub;
         dst_we_o <= ~(dec.dst_mod == MOD_PFX);
         side_fx_o <= next_side_fx;
      end
   end

   // ----------------------------------------------------------------
   // Hardware stack
   // ----------------------------------------------------------------
   logic [15:0] stk_mem [STK_DEPTH];
   logic [3:0] stack_index;
   logic [3:0] next_stack_index;
   logic stk_push;
   logic stk_pop;
   logic [15:0] stk_push_val;

   always_comb begin
      stk_push = (stk_op_i == RCD_STK_CALL) || (stk_op_i == RCD_STK_PUSH) ||
                 (stk_op_i == RCD_STK_IRQ);
      stk_pop = (stk_op_i == RCD_STK_RET) || (stk_op_i == RCD_STK_INTERRUPT_RETURN) ||
                (stk_op_i == RCD_STK_POP) || (stk_op_i == RCD_STK_INTERRUPT_ACK_POP);
      stk_push_val = (stk_op_i == RCD_STK_PUSH) ? stk_wdata_i : pc_i;
      next_stack_index = stack_index;
      if (stk_push) begin
         next_stack_index = stack_index + 4'd1;
      end else if (stk_pop) begin
         next_stack_index = stack_index - 4'd1;
      end
   end

   for (genvar e = 0; e < STK_DEPTH; e++) begin : g_stk
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            stk_mem[e] <= 16'h0000;
         end else if (stk_push && next_stack_index == 4'(e)) begin
            stk_mem[e] <= stk_push_val;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stack_index <= STK_IDX_RST;
         stk_rdata_o <= 16'h0000;
      end else begin
         stack_index <= next_stack_index;
         if (stk_pop) begin
            stk_rdata_o <= stk_mem[stack_index];
         end
      end
   end

   assign stack_index_o = stack_index;

   // ----------------------------------------------------------------
   // Data pointers
   // ----------------------------------------------------------------
   logic [15:0] dp [NUM_DP];
   logic [15:0] next_dp [NUM_DP];

   for (genvar d = 0; d < NUM_DP; d++) begin : g_dp
      always_comb begin
         next_dp[d] = dp[d];
         if (dp_load_en_i && dp_sel_i == 2'(d)) begin
            next_dp[d] = dp_load_i;
         end else if (dp_access_i && dp_sel_i == 2'(d)) begin
            if (dp_inc_i[d]) begin
               next_dp[d] = dp[d] + 16'h0001;
            end else if (dp_dec_i[d]) begin
               next_dp[d] = dp[d] - 16'h0001;
            end
         end
      end
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            dp[d] <= 16'h0000;
         end else begin
            dp[d] <= next_dp[d];
         end
      end
   end

   assign dp_o = dp;

   // ----------------------------------------------------------------
   // Memory map, boot, lock
   // ----------------------------------------------------------------
   logic [15:0] pwd [PWD_WORDS];
   logic [PWD_WORDS-1:0] pwd_match;
   logic code_lock_bit;
   logic pwd_ok;
   logic next_code_lock_bit;
   logic next_pwd_ok;
   logic [3:0] pwd_cnt;
   logic [3:0] next_pwd_cnt;
   logic pwd_run;
   logic next_pwd_run;
   logic in_rom;

   for (genvar w = 0; w < PWD_WORDS; w++) begin : g_pwd
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            pwd[w] <= PWD_ERASED;
         end else if (mass_erase_i) begin
            pwd[w] <= PWD_ERASED;
         end else if (flash_word_en_i && flash_word_idx_i == 4'(w)) begin
            pwd[w] <= flash_word_i;
         end
      end
      assign pwd_match[w] = (pwd[w] == pwd_word_i);
   end

   always_comb begin
      next_code_lock_bit = code_lock_bit;
      if (code_lock_clr_i) begin
         next_code_lock_bit = 1'b0;
      end
      next_pwd_cnt = pwd_cnt;
      next_pwd_ok = pwd_ok;
      next_pwd_run = pwd_run;
      // The run flag remembers that every word of this round has matched so far.
      if (pwd_word_en_i) begin
         next_pwd_cnt = pwd_cnt + 4'd1;
         next_pwd_run = pwd_match[pwd_cnt] && (pwd_run || pwd_cnt == 4'h0);
         if (!pwd_match[pwd_cnt]) begin
            next_pwd_ok = 1'b0;
         end else if (pwd_cnt == 4'hF && pwd_run) begin
            next_pwd_ok = 1'b1;
         end
      end
      in_rom = (pc_i >= UROM_BASE) && (pc_i < UROM_BASE + UROM_SIZE);
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         code_lock_bit <= CODE_LOCK_RST;
         pwd_ok <= 1'b0;
         pwd_cnt <= 4'h0;
         pwd_run <= 1'b0;
         debug_ok_o <= 1'b0;
         rom_sel_o <= 1'b0;
         boot_pc_o <= UROM_BASE;
         map_data_in_code_o <= 1'b0;
         map_code_in_data_o <= 1'b0;
      end else begin
         code_lock_bit <= next_code_lock_bit;
         pwd_ok <= next_pwd_ok;
         pwd_cnt <= next_pwd_cnt;
         pwd_run <= next_pwd_run;
         debug_ok_o <= ~next_code_lock_bit | next_pwd_ok;
         rom_sel_o <= in_rom;
         boot_pc_o <= loader_entry_bit_o ? UROM_BASE : USER_START;
         map_data_in_code_o <= (map_mode_i == RCD_MAP_DATA_IN_CODE) ||
                               (map_mode_i == RCD_MAP_UNIFIED);
         map_code_in_data_o <= (map_mode_i == RCD_MAP_CODE_IN_DATA) ||
                               (map_mode_i == RCD_MAP_UNIFIED);
      end
   end

   assign code_lock_bit_o = code_lock_bit;

   // ----------------------------------------------------------------
   // Loader entry and port select
   // ----------------------------------------------------------------
   logic jtag_s1;
   logic jtag_s2;
   logic next_entry;
   logic next_port;

   always_comb begin
      next_entry = loader_entry_bit_o;
      next_port = loader_port_select_o;
      if (jtag_s2) begin
         next_entry = 1'b1;
         next_port = 1'b0;
      end else if (app_loader_cfg_i) begin
         next_entry = 1'b1;
         next_port = app_port_uart_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         jtag_s1 <= 1'b0;
         jtag_s2 <= 1'b0;
         loader_entry_bit_o <= 1'b0;
         loader_port_select_o <= 1'b0;
      end else begin
         jtag_s1 <= jtag_loader_set_i;
         jtag_s2 <= jtag_s1;
         loader_entry_bit_o <= next_entry;
         loader_port_select_o <= next_port;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   stack_push_inc_a: assert property (stk_push |=> stack_index == $past(stack_index) + 4'd1)
      else $error("push did not advance stack index");
   stack_pop_dec_a: assert property (stk_pop |=> stack_index == $past(stack_index) - 4'd1)
      else $error("pop did not lower stack index");
   pop_read_entry_a: assert property (stk_pop |=> stk_rdata_o == $past(stk_mem[stack_index]))
      else $error("pop returned wrong entry");
   push_store_a: assert property (stk_op_i == RCD_STK_PUSH |=> stk_mem[stack_index] == $past(stk_wdata_i))
      else $error("push did not store value");
   imm_source_a: assert property (!insn_i[15] |=> src_val_o == {8'h00, $past(insn_i[7:0])})
      else $error("immediate source wrong");
   dest_module_a: assert property (1'b1 |=> dst_mod_o == $past(insn_i[11:8]))
      else $error("destination module wrong");
   prefix_extend_a: assert property (pfx_valid |=> dst_sub_o[4:3] == $past(dest_prefix_reg[1:0]))
      else $error("prefix bits not applied");
   lock_gate_a: assert property (code_lock_bit && !pwd_ok && !code_lock_clr_i && !pwd_word_en_i |=> !debug_ok_o)
      else $error("debug opened while locked");
   unlock_open_a: assert property (!code_lock_bit |=> debug_ok_o)
      else $error("debug closed while unlocked");
   erase_pwd_a: assert property (mass_erase_i |=> pwd[0] == PWD_ERASED && pwd[15] == PWD_ERASED)
      else $error("erase left password set");
   dp_step_a: assert property (dp_access_i && !dp_load_en_i && dp_sel_i == 2'd0 && dp_inc_i[0] |=> dp[0] == $past(dp[0]) + 16'h0001)
      else $error("pointer did not step");
   jtag_entry_a: assert property (jtag_loader_set_i |-> ##3 loader_entry_bit_o && !loader_port_select_o)
      else $error("loader entry not set");

   call_c: cover property (stk_op_i == RCD_STK_CALL ##1 stk_op_i == RCD_STK_RET);
   prefix_c: cover property (next_pfx_valid ##1 pfx_valid);
   uart_c: cover property (app_loader_cfg_i && app_port_uart_i ##1 loader_port_select_o);

endmodule : rcd_core

// file: rcd_core_tb_top.sv
`timescale 1ns/1ps
module rcd_core_tb_top;
   import rcd_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk_sys_i;
   logic rst_n_i;
   logic [15:0] insn, src_data, acc, pc, stk_wdata, dp_load, pwd_word, flash_word;
   rcd_stk_e stk_op;
   rcd_map_e map_mode;
   logic [1:0] dp_sel;
   logic dp_access, dp_load_en, lock_clr, erase, pwd_en, flash_en, app_cfg, app_uart;
   logic jtag_req, jtag_set;
   logic [2:0] dp_inc, dp_dec;
   logic [3:0] flash_idx, dst_mod, stk_idx;
   logic [4:0] dst_sub;
   logic [15:0] src_val, stk_rdata, boot_pc;
   logic [15:0] dp_w [NUM_DP];
   logic dst_we, side_fx, rom_sel, lock_bit, debug_ok, ld_entry, ld_port, dic, cid;
   logic [15:0] pcs [4];
   int err_count;
   int cmp_count;
   int i;

   rcd_jtag_host u_host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(jtag_req),
      .jtag_loader_set_o(jtag_set));

   rcd_core u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .insn_i(insn),
      .src_data_i(src_data), .acc_i(acc), .pc_i(pc), .stk_op_i(stk_op),
      .stk_wdata_i(stk_wdata), .dp_sel_i(dp_sel), .dp_access_i(dp_access),
      .dp_inc_i(dp_inc), .dp_dec_i(dp_dec), .dp_load_i(dp_load), .dp_load_en_i(dp_load_en),
      .map_mode_i(map_mode), .code_lock_clr_i(lock_clr), .mass_erase_i(erase),
      .pwd_word_i(pwd_word), .pwd_word_en_i(pwd_en), .flash_word_i(flash_word),
      .flash_word_en_i(flash_en), .flash_word_idx_i(flash_idx),
      .jtag_loader_set_i(jtag_set), .app_loader_cfg_i(app_cfg),
      .app_port_uart_i(app_uart), .src_val_o(src_val), .dst_mod_o(dst_mod),
      .dst_sub_o(dst_sub), .dst_we_o(dst_we), .side_fx_o(side_fx),
      .stk_rdata_o(stk_rdata), .stack_index_o(stk_idx), .dp_o(dp_w),
      .boot_pc_o(boot_pc), .rom_sel_o(rom_sel), .code_lock_bit_o(lock_bit),
      .debug_ok_o(debug_ok), .loader_entry_bit_o(ld_entry),
      .loader_port_select_o(ld_port), .map_data_in_code_o(dic),
      .map_code_in_data_o(cid));

   // ----------------------------------------------------------------
   // Clock, tasks
   // ----------------------------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Inputs change one nanosecond after the rising edge; outputs are settled then.
   task automatic step();
      @(posedge clk_sys_i);
      #1;
   endtask : step

   task automatic do_reset();
      rst_n_i = 1'b0;
      repeat (4) step();
      chk(boot_pc, 16'h8000);
      rst_n_i = 1'b1;
   endtask : do_reset

   task automatic stk(input rcd_stk_e op, input logic [3:0] idx, input logic [15:0] rd);
      stk_op = op;
      step();
      stk_op = RCD_STK_NONE;
      step();
      chk({12'h000, stk_idx}, {12'h000, idx});
      if (op >= RCD_STK_RET) chk(stk_rdata, rd);
   endtask : stk

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      err_count = 0;
      cmp_count = 0;
      {insn, src_data, acc, pc, stk_wdata, dp_load, pwd_word, flash_word} = '0;
      stk_op = RCD_STK_NONE;
      map_mode = RCD_MAP_HARVARD;
      {dp_sel, dp_access, dp_load_en, lock_clr, erase, pwd_en, flash_en} = '0;
      {app_cfg, app_uart, jtag_req, dp_inc, dp_dec, flash_idx} = '0;
      pcs = '{16'h7FFF, 16'h8000, 16'h8FFF, 16'h9000};
      do_reset();
      step();
      chk({12'h000, stk_idx}, 16'h000F);
      chk({15'h0000, lock_bit}, 16'h0001);
      chk(boot_pc, 16'h0000);
      chk({14'h0000, ld_entry, ld_port}, 16'h0000);
      // Module 11 subindex 0 arms the prefix, so module 12 carries its low two source bits.
      for (i = 0; i < 16; i++) begin
         insn = {1'b0, (i == 11) ? 3'b000 : 3'b001, i[3:0], 8'hA5};
         step();
         chk({12'h000, dst_mod}, i[15:0]);
         chk({11'h000, dst_sub}, (i == 12) ? 16'h0009 : 16'(i != 11));
         chk({15'h0000, dst_we}, {15'h0000, i != 11});
         chk({15'h0000, side_fx}, {15'h0000, i inside {9, 12, 13, 15}});
         chk(src_val, 16'h00A5);
      end
      acc = 16'h1357;
      src_data = 16'h2468;
      insn = 16'h8319;
      step();
      chk(src_val, 16'h1357);
      insn = 16'h8314;
      step();
      chk(src_val, 16'h2468);
      chk({12'h000, dst_mod}, 16'h0003);
      stk_wdata = 16'hBEEF;
      pc = 16'h1234;
      stk(RCD_STK_PUSH, 4'h0, 16'h0000);
      stk(RCD_STK_CALL, 4'h1, 16'h0000);
      pc = 16'h5555;
      stk(RCD_STK_IRQ, 4'h2, 16'h0000);
      stk(RCD_STK_INTERRUPT_RETURN, 4'h1, 16'h5555);
      stk(RCD_STK_RET, 4'h0, 16'h1234);
      stk(RCD_STK_POP, 4'hF, 16'hBEEF);
      stk_wdata = 16'h0A0A;
      stk(RCD_STK_PUSH, 4'h0, 16'h0000);
      stk(RCD_STK_INTERRUPT_ACK_POP, 4'hF, 16'h0A0A);
      dp_load = 16'h0100;
      dp_load_en = 1'b1;
      step();
      dp_load_en = 1'b0;
      dp_access = 1'b1;
      dp_inc = 3'b001;
      step();
      dp_access = 1'b0;
      chk(dp_w[0], 16'h0101);
      dp_sel = 2'h1;
      dp_load = 16'h0200;
      dp_load_en = 1'b1;
      step();
      dp_load_en = 1'b0;
      dp_access = 1'b1;
      dp_dec = 3'b010;
      step();
      dp_access = 1'b0;
      chk(dp_w[1], 16'h01FF);
      dp_sel = 2'h2;
      dp_load_en = 1'b1;
      step();
      dp_load_en = 1'b0;
      dp_access = 1'b1;
      dp_inc = 3'b100;
      step();
      dp_access = 1'b0;
      chk(dp_w[2], 16'h0201);
      chk(dp_w[1], 16'h01FF);
      for (i = 0; i < 4; i++) begin
         map_mode = rcd_map_e'(i[1:0]);
         step();
         chk({14'h0000, dic, cid}, {14'h0000, i[0], i[1]});
      end
      for (i = 0; i < 4; i++) begin
         pc = pcs[i];
         step();
         chk({15'h0000, rom_sel}, {15'h0000, i == 1 || i == 2});
      end
      // Erased password words are all ones, so sixteen zero words must not unlock.
      erase = 1'b1;
      step();
      erase = 1'b0;
      flash_en = 1'b1;
      flash_word = 16'hFFFF;
      step();
      flash_en = 1'b0;
      pwd_en = 1'b1;
      repeat (16) step();
      pwd_en = 1'b0;
      step();
      chk({15'h0000, debug_ok}, 16'h0000);
      chk({15'h0000, lock_bit}, 16'h0001);
      // Sixteen all-ones words match the erased password and open debug.
      pwd_word = 16'hFFFF;
      pwd_en = 1'b1;
      repeat (16) step();
      pwd_en = 1'b0;
      step();
      chk({15'h0000, debug_ok}, 16'h0001);
      lock_clr = 1'b1;
      step();
      lock_clr = 1'b0;
      step();
      chk({14'h0000, lock_bit, debug_ok}, 16'h0001);
      app_uart = 1'b1;
      app_cfg = 1'b1;
      step();
      app_cfg = 1'b0;
      step();
      chk({14'h0000, ld_entry, ld_port}, 16'h0003);
      jtag_req = 1'b1;
      do_reset();
      repeat (4) step();
      jtag_req = 1'b0;
      chk({14'h0000, ld_entry, ld_port}, 16'h0002);
      chk(boot_pc, 16'h8000);
      chk({12'h000, stk_idx}, 16'h000F);
      print_verdict();
   end

   initial begin
      repeat (5000) @(posedge clk_sys_i);
      err_count++;
      print_verdict();
   end
endmodule : rcd_core_tb_top

// file: rcd_jtag_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// JTAG host model
// ----------------------------------------------------------------
// The host raises the loader request only while the device is held in reset,
// then keeps it for a few cycles after release so the synchroniser sees it.
module rcd_jtag_host (
   // Clock and reset of the device
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Bench command
   input wire logic req_i,
   // Loader request line
   output logic jtag_loader_set_o
);
   logic [2:0] hold;

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold <= 3'h0;
         jtag_loader_set_o <= req_i;
      end else if (hold != 3'h7) begin
         hold <= hold + 3'h1;
      end else begin
         jtag_loader_set_o <= 1'b0;
      end
   end
endmodule : rcd_jtag_host

// file: rcd_pkg.sv
package rcd_pkg;

   // ----------------------------------------------------------------
   // Instruction word layout
   // ----------------------------------------------------------------
   localparam int INSN_W = 16;
   localparam int FMT_BIT = 15;
   localparam int SRC_MOD_LSB = 0;
   localparam int SRC_IDX_LSB = 4;
   localparam int DST_MOD_LSB = 8;
   localparam int DST_SUB_LSB = 12;

   // ----------------------------------------------------------------
   // Core module numbers and special destinations
   // ----------------------------------------------------------------
   localparam logic [3:0] MOD_ACC = 4'h9;
   localparam logic [3:0] MOD_PFX = 4'hB;
   localparam logic [3:0] MOD_IP = 4'hC;
   localparam logic [3:0] MOD_STK = 4'hD;
   localparam logic [3:0] MOD_DP = 4'hF;
   localparam logic [7:0] REG_STACK_IDX = 8'h1D;
   localparam logic [7:0] REG_STK_DATA = 8'h0D;
   localparam logic [7:0] REG_DP_DATA = 8'h0F;

   // ----------------------------------------------------------------
   // Stack, pointers, memory map
   // ----------------------------------------------------------------
   localparam int STK_DEPTH = 16;
   localparam logic [3:0] STK_IDX_RST = 4'hF;
   localparam int NUM_DP = 3;
   localparam logic [15:0] UROM_BASE = 16'h8000;
   localparam logic [15:0] UROM_SIZE = 16'h1000;
   localparam logic [15:0] USER_START = 16'h0000;
   localparam logic [15:0] PWD_FIRST = 16'h0010;
   localparam logic [15:0] PWD_LAST = 16'h001F;
   localparam logic [15:0] PWD_ERASED = 16'hFFFF;
   localparam int PWD_WORDS = 16;
   localparam logic CODE_LOCK_RST = 1'b1;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RCD_MAP_HARVARD,
      RCD_MAP_DATA_IN_CODE,
      RCD_MAP_CODE_IN_DATA,
      RCD_MAP_UNIFIED
   } rcd_map_e;

   typedef enum logic [2:0] {
      RCD_STK_NONE,
      RCD_STK_CALL,
      RCD_STK_PUSH,
      RCD_STK_IRQ,
      RCD_STK_RET,
      RCD_STK_INTERRUPT_RETURN,
      RCD_STK_POP,
      RCD_STK_INTERRUPT_ACK_POP
   } rcd_stk_e;

   typedef struct packed {
      logic imm;
      logic [7:0] src;
      logic [3:0] src_mod;
      logic [3:0] src_idx;
      logic [3:0] dst_mod;
      logic [4:0] dst_sub;
      logic pfx_used;
   } rcd_dec_s;

   typedef struct packed {
      logic pwd_ok;
      logic erase;
      logic load;
   } rcd_lock_s;

endpackage : rcd_pkg
